// *** src/gdsp_pkg.sv ***
// package for the gauge driver serial command port: shared constants
// assumes both ends run on one 100 MHz system clock; link pins are sampled, not clocked
package gdsp_pkg;
    localparam int WORD_W = 16;
    localparam int CNT_W = 5;
    localparam int CLK_MHZ = 100;
    // serial clock half period in system clocks, gives 80 ns link clock
    localparam int HALF_DIV = 4;
    // least deselect time between frames, in ns, and its count of cycles
    localparam int CS_GAP_NS = 5000;
    localparam int CS_GAP_CYC = (CS_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage

// *** src/gdsp_link_if.sv ***
// link between the master end and the gauge device end
// assumes the bench resolves the serial output wire from its enable
`timescale 1ns/10ps
`default_nettype none
interface gdsp_link_if;
    logic cs_b;
    logic sclk;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic rst_b;
    modport device (input cs_b, input sclk, input mosi, input rst_b, output miso, output miso_oe);
    modport host (output cs_b, output sclk, output mosi, output rst_b, input miso, input miso_oe);
endinterface
`default_nettype wire

// *** src/gdsp_device.sv ***
// device end: serial shift port with status out, pass-through and word commit
// assumes link pins come from another domain; a two-entry buffer feeds received words out
`timescale 1ns/10ps
`default_nettype none
module gdsp_device
    import gdsp_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic rst_b_i,
    // link
    gdsp_link_if.device link,
    // user side
    input wire logic [15:0] status_i,
    output logic [15:0] cmd_data_o,
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic drop_o
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [2:0] cs_s;
        logic [2:0] ck_s;
        logic [2:0] di_s;
        logic [15:0] shin;
        logic [31:0] shout;
        logic [CNT_W-1:0] cnt;
        logic any;
        logic so;
        logic oe;
        logic [1:0][15:0] buf_d;
        logic [1:0] fill;
        logic drop;
        logic vld;
    } gdsp_dev_t;
    gdsp_dev_t r, next_r;
    logic cs_b, cs_prev, ck, ck_prev, di;
    logic push;

    always_comb begin
        next_r = r;
        next_r.cs_s = {r.cs_s[1:0], link.cs_b};
        next_r.ck_s = {r.ck_s[1:0], link.sclk};
        next_r.di_s = {r.di_s[1:0], link.mosi};
        cs_b = r.cs_s[1];
        cs_prev = r.cs_s[2];
        ck = r.ck_s[1];
        ck_prev = r.ck_s[2];
        di = r.di_s[1];
        push = 1'b0;
        next_r.drop = 1'b0;
        // ****************************************
        // shifting
        // ****************************************
        if (cs_prev && !cs_b) begin
            next_r.shout = {status_i, 16'h0000};
            next_r.cnt = '0;
            next_r.any = 1'b0;
            next_r.so = status_i[15];
        end else if (!cs_b) begin
            if (ck_prev && !ck) begin
                next_r.shin = {r.shin[14:0], di};
                // slot 16 reaches the top right after the last status bit, for any frame length
                next_r.shout[16] = di;
                next_r.cnt = (r.cnt[3:0] == 4'hF) ? 5'h10 : CNT_W'(r.cnt[3:0] + 4'h1);
                next_r.any = 1'b1;
            end
            if (!ck_prev && ck) begin
                next_r.shout = {r.shout[30:0], 1'b0};
                // first rise repeats the msb shown at select fall, so no status bit is lost
                next_r.so = r.shout[31];
            end
        end
        // word boundary marker: cnt[4] set when a multiple of sixteen was just reached
        if (!cs_b && ck_prev && !ck && r.cnt[3:0] != 4'hF) begin
            next_r.cnt[4] = 1'b0;
        end
        next_r.oe = !cs_b;
        // ****************************************
        // commit at select rise
        // ****************************************
        if (!cs_prev && cs_b && r.any) begin
            if (r.cnt[4]) begin
                push = 1'b1;
            end else begin
                next_r.drop = 1'b1;
            end
        end
        // ****************************************
        // two-entry buffer; a full buffer drops the word
        // ****************************************
        if (cmd_valid_o && cmd_ready_i) begin
            next_r.buf_d[0] = r.buf_d[1];
            next_r.fill = r.fill - 2'h1;
        end
        if (push) begin
            if (next_r.fill < BUF_DEPTH) begin
                next_r.buf_d[next_r.fill[0]] = r.shin;
                next_r.fill = next_r.fill + 2'h1;
            end else begin
                next_r.drop = 1'b1;
            end
        end
        next_r.vld = (next_r.fill != 2'h0);
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !link.rst_b) begin
            r <= '0;
            r.cs_s <= 3'h7;
            r.shout <= {STATUS_RST, 16'h0000};
        end else begin
            r <= next_r;
        end
    end

    assign link.miso = r.so;
    assign link.miso_oe = r.oe;
    assign cmd_data_o = r.buf_d[0];
    assign cmd_valid_o = r.vld;
    assign drop_o = r.drop;
endmodule
`default_nettype wire

// *** src/gdsp_host.sv ***
// host end: sends one sixteen-bit word per frame and returns the status read back
// assumes the device end answers on the serial output while selected
`timescale 1ns/10ps
`default_nettype none
module gdsp_host
    import gdsp_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic rst_b_i,
    // link
    gdsp_link_if.host link,
    // user side
    input wire logic [15:0] tx_data_i,
    input wire logic tx_valid_i,
    output logic tx_ready_o,
    input wire logic dev_reset_i,
    output logic [15:0] rx_data_o,
    output logic rx_valid_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT, ST_GAP} gdsp_hst_e_t;
    typedef struct packed {
        gdsp_hst_e_t st;
        logic [2:0] mi_s;
        logic [15:0] tx;
        logic [15:0] rx;
        logic [CNT_W-1:0] bits;
        logic [9:0] tmr;
        logic cs_b;
        logic sclk;
        logic rst_b;
        logic rdy;
        logic rv;
    } gdsp_hst_t;
    gdsp_hst_t r, next_r;

    always_comb begin
        next_r = r;
        next_r.mi_s = {r.mi_s[1:0], link.miso};
        next_r.rv = 1'b0;
        next_r.rst_b = !dev_reset_i;
        next_r.rdy = 1'b0;
        case (r.st)
            ST_IDLE: begin
                next_r.rdy = 1'b1;
                if (tx_valid_i && r.rdy) begin
                    next_r.tx = tx_data_i;
                    next_r.cs_b = 1'b0;
                    next_r.tmr = 10'(HALF_DIV - 1);
                    next_r.bits = '0;
                    next_r.rdy = 1'b0;
                    next_r.st = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (r.tmr == 10'h000) begin
                    next_r.st = ST_SHIFT;
                    next_r.tmr = 10'(HALF_DIV - 1);
                end else begin
                    next_r.tmr = r.tmr - 10'h001;
                end
            end
            ST_SHIFT: begin
                if (r.tmr != 10'h000) begin
                    next_r.tmr = r.tmr - 10'h001;
                end else begin
                    next_r.tmr = 10'(HALF_DIV - 1);
                    if (!r.sclk) begin
                        if (r.bits == 5'h10) begin
                            next_r.cs_b = 1'b1;
                            next_r.rx = {r.rx[14:0], r.mi_s[1]};
                            next_r.rv = 1'b1;
                            next_r.tmr = 10'(CS_GAP_CYC);
                            next_r.st = ST_GAP;
                        end else begin
                            next_r.sclk = 1'b1;
                            if (r.bits != 5'h00) begin
                                next_r.rx = {r.rx[14:0], r.mi_s[1]};
                                // data moves with the rise, half a period clear of the sampling fall
                                next_r.tx = {r.tx[14:0], 1'b0};
                            end
                        end
                    end else begin
                        next_r.sclk = 1'b0;
                        next_r.bits = r.bits + 5'h01;
                    end
                end
            end
            ST_GAP: begin
                if (r.tmr == 10'h000) begin
                    next_r.st = ST_IDLE;
                end else begin
                    next_r.tmr = r.tmr - 10'h001;
                end
            end
            default: next_r.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            r <= '0;
            r.cs_b <= 1'b1;
            r.rst_b <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign link.cs_b = r.cs_b;
    assign link.sclk = r.sclk;
    assign link.mosi = r.tx[15];
    assign link.rst_b = r.rst_b;
    assign tx_ready_o = r.rdy;
    assign rx_data_o = r.rx;
    assign rx_valid_o = r.rv;
endmodule
`default_nettype wire

// *** sim/gdsp_link_props.sv ***
// checker for the link between the host end and the device end
// assumes it sees the interface signals and the system clock
`timescale 1ns/10ps
`default_nettype none
module gdsp_link_props
    import gdsp_pkg::*;
(
    // system
    input wire logic clk_i,
    input wire logic rst_b_i,
    // link
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic rst_b
);
    // ****************
    // helper counters
    // ****************
    // gap starts full so the first frame after reset is legal
    int gap;
    int bits;
    logic ps;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            gap <= CS_GAP_CYC;
            bits <= 0;
            ps <= 1'b0;
        end else begin
            gap <= !cs_b ? 0 : (gap < CS_GAP_CYC ? gap + 1 : gap);
            bits <= cs_b ? 0 : bits + int'(sclk && !ps);
            ps <= sclk;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // the device sees select through two flops, so the enable may lag by three cycles
    a_oe_while_sel: assert property (cs_b && $past(cs_b) && $past(cs_b, 2) && $past(cs_b, 3) |-> !miso_oe)
        else $error("serial out enabled while deselected");
    a_sclk_at_select: assert property ($changed(cs_b) |-> !sclk && !$past(sclk))
        else $error("serial clock high at select change");
    a_lead_low: assert property ($fell(cs_b) |-> !sclk [*4])
        else $error("serial clock too soon after select");
    a_out_on_rise: assert property (!cs_b && miso_oe && $past(miso_oe) && $changed(miso) |-> sclk)
        else $error("serial out moved outside clock high");
    a_word_len: assert property ($rose(cs_b) |-> bits == WORD_W)
        else $error("frame not one word long");
    a_select_gap: assert property ($fell(cs_b) |-> gap >= CS_GAP_CYC)
        else $error("deselect gap too short");
    a_half_period: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
        else $error("serial clock high phase wrong");
    a_reset_quiet: assert property (!rst_b [*3] |-> !miso_oe)
        else $error("serial out enabled in reset");
    c_frame: cover property ($rose(cs_b));
    c_drive: cover property ($rose(miso_oe));
    c_reset: cover property ($fell(rst_b));
endmodule
`default_nettype wire

// *** sim/test_gauge_driver_spi_command_port.sv ***
// bench: host and device ends joined by the link, and a second device driven bit by bit
// assumes the design and the checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin chk_e = 32'(e); tests_run++; \
    if (chk_e !== 32'(s)) begin errors++; \
    $display("[ERR] %s exp %h got %h", n, chk_e, s); end end
module test_gauge_driver_spi_command_port;
    import gdsp_pkg::*;
    // ****************
    // bench
    // ****************
    logic clk_i = 1'b0, rst_b_i = 1'b0, stall = 1'b0, pc = 1'b1, ps = 1'b0;
    logic tx_valid_i = 1'b0, dev_reset_i = 1'b0, cmd_ready_i = 1'b0;
    logic tx_ready_o, rx_valid_o, cmd_valid_o, drop_o, c2_valid, d2_drop;
    logic [15:0] tx_data_i = 16'h0000, status_i = 16'h0000, st2 = 16'hA5C3, wsh = 16'h0000;
    logic [15:0] rx_data_o, cmd_data_o, c2_data, cmd_q[$], rx_q[$], w_q[$], c2_q[$];
    logic [31:0] so, chk_e;
    int errors = 0, tests_run = 0, drops = 0, drops2 = 0, cyc = 0, seed = 40;
    gdsp_link_if link();
    gdsp_link_if l2();
    gdsp_host gdsp_host_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .tx_data_i(tx_data_i),
        .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .dev_reset_i(dev_reset_i),
        .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o));
    gdsp_device gdsp_device_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(link), .status_i(status_i),
        .cmd_data_o(cmd_data_o), .cmd_valid_o(cmd_valid_o), .cmd_ready_i(cmd_ready_i),
        .drop_o(drop_o));
    gdsp_device gdsp_device_i2 (.clk_i(clk_i), .rst_b_i(rst_b_i), .link(l2), .status_i(st2),
        .cmd_data_o(c2_data), .cmd_valid_o(c2_valid), .cmd_ready_i(1'b1), .drop_o(d2_drop));
    gdsp_link_props gdsp_link_props_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .cs_b(link.cs_b),
        .sclk(link.sclk), .miso(link.miso), .miso_oe(link.miso_oe), .rst_b(link.rst_b));
    always #5 clk_i = ~clk_i;
    always @(negedge clk_i) cmd_ready_i <= !stall && ($random(seed) & 1) != 0;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        pc <= link.cs_b;
        ps <= link.sclk;
        if (!ps && link.sclk === 1'b1) wsh <= {wsh[14:0], link.mosi};
        if (!pc && link.cs_b === 1'b1) `CHK("wire", w_q.pop_front(), wsh)
        if (cmd_valid_o === 1'b1 && cmd_ready_i) `CHK("cmd", cmd_q.pop_front(), cmd_data_o)
        if (rx_valid_o === 1'b1) `CHK("status", rx_q.pop_front(), rx_data_o)
        if (c2_valid === 1'b1) `CHK("cmd2", c2_q.pop_front(), c2_data)
        if (drop_o === 1'b1) drops++;
        if (d2_drop === 1'b1) drops2++;
        // whole run is near 6500 cycles
        if (cyc > 40000) begin errors++; wrap_up(); end
    end
    task send(input logic [15:0] d, input logic keep);
        while (tx_ready_o !== 1'b1) @(negedge clk_i);
        status_i = 16'($random(seed));
        tx_data_i = d;
        tx_valid_i = 1'b1;
        w_q.push_back(d);
        rx_q.push_back(status_i);
        if (keep) cmd_q.push_back(d);
        @(negedge clk_i);
        tx_valid_i = 1'b0;
    endtask
    task idle;
        repeat (2) @(negedge clk_i);
        while (tx_ready_o !== 1'b1) @(negedge clk_i);
    endtask
    // clock kept low at select changes, 80 ns link clock, gap after each frame
    task bang(input int n, input logic [31:0] v);
        so = 32'h0000_0000;
        l2.cs_b = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (4) @(negedge clk_i);
            l2.mosi = v[i];
            l2.sclk = 1'b1;
            repeat (4) @(negedge clk_i);
            so = {so[30:0], l2.miso};
            l2.sclk = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        l2.cs_b = 1'b1;
        repeat (CS_GAP_CYC) @(negedge clk_i);
    endtask
    task wrap_up;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        l2.cs_b = 1'b1;
        l2.sclk = 1'b0;
        l2.mosi = 1'b0;
        l2.rst_b = 1'b1;
        repeat (2) @(negedge clk_i);
        rst_b_i = 1'b1;
        repeat (3) send(16'($random(seed)), 1'b1);
        idle();
        // receiver stalls: two words fill the buffer, the third is lost
        stall = 1'b1;
        send(16'hFFFF, 1'b1);
        send(16'h0001, 1'b1);
        send(16'h8000, 1'b0);
        idle();
        `CHK("drops", 1, drops)
        stall = 1'b0;
        while (cmd_q.size() != 0) @(negedge clk_i);
        dev_reset_i = 1'b1;
        repeat (20) @(negedge clk_i);
        dev_reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        send(16'h1234, 1'b1);
        idle();
        `CHK("drops", 1, drops)
        bang(8, 32'h0000_005A);
        `CHK("drops2", 1, drops2)
        c2_q.push_back(16'h3C3C);
        bang(32, 32'hC3C3_3C3C);
        `CHK("chain", {st2, 16'hC3C3}, so)
        // toggles while deselected must not count as bits
        repeat (8) begin
            l2.sclk = ~l2.sclk;
            l2.mosi = 1'($random(seed));
            @(negedge clk_i);
        end
        c2_q.push_back(16'h9669);
        bang(16, 32'h0000_9669);
        `CHK("drops3", 1, drops2)
        while (c2_q.size() != 0 || rx_q.size() != 0 || cmd_q.size() != 0) @(negedge clk_i);
        wrap_up();
    end
endmodule
`default_nettype wire
